/* File: dv/cga_smb_host.sv */
// serial management bus host model driving the slave's clock and data lines
`timescale 1ns/1ps
module cga_smb_host #(
  parameter logic [6:0] ADDR = 7'h69
) (
  input wire logic core_clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow,
  output logic [7:0] rdByte,
  output logic rdValid
);
  // bus idles released with the clock high
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
    rdByte = 8'h00;
    rdValid = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one bit: data moves mid low phase, sampled mid high phase
  task automatic xbit(input logic b, output logic s);
    sdaLow <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    s = sdaLine;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sdaLow <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sdaLow <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sdaLow <= 1'b0;
    tick(8);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xbit(b[i], s);
    xbit(1'b1, s);
    ack = ~s;
  endtask
  // receive a byte, flag it for one cycle, then ack or nack
  task automatic recv(input logic last);
    logic s;
    logic [7:0] v;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, s);
      v[i] = s;
    end
    rdByte <= v;
    rdValid <= 1'b1;
    tick(1);
    rdValid <= 1'b0;
    xbit(last, s);
  endtask
  // block write of one byte at index idx
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
    logic k0, k1, k2, k3;
    start();
    send({a, 1'b0}, k0);
    send(idx, k1);
    send(8'h01, k2);
    send(d, k3);
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask
  // block read: count byte first, then n bytes from idx, last one nacked
  task automatic rd(input logic [7:0] idx, input int n);
    logic k;
    start();
    send({ADDR, 1'b0}, k);
    send(idx, k);
    start();
    send({ADDR, 1'b1}, k);
    recv(1'b0);
    for (int i = 1; i <= n; i++)
      recv(i == n);
    stop();
  endtask
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the auxiliary register slice
`timescale 1ns/1ps
module testbench;
  import cga_pkg::*;
  localparam logic [6:0] ADDR = 7'h69;
  localparam logic [7:0] READ_COUNT_EXP = 8'h08;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic refClk = 1'b0;
  logic refLostN, freqSelPin, freqSelRegCtrl, freqSelReg, ok;
  logic scl, sdaLow, sdaLine, smbDataOut, smbDataOe, rdValid, spreadSrcFilter, selFreq25;
  logic [1:0] spreadPin, hs;
  logic [6:0] enablePinN;
  logic [7:0] rdByte, d;
  logic [3:0] spr;
  logic [15:0] e;
  logic [15:0] expQ[$];
  logic [31:0] seed = 32'h9C44A4D8;
  cga_spread_t hundredSpread, selectableSpread;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // core clock and free-running reference clock
  always #5 core_clk = ~core_clk;
  initial
  begin
    #3.7;
    forever #80 refClk = ~refClk;
  end
  // open-drain data line with pull-up
  assign sdaLine = ~(sdaLow | smbDataOe);
  cga_aux_regs #(.SLAVE_ADDR(ADDR), .WINDOW_REF(64), .EXPECT_CORE(1022)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .platform_time_input(refClk), .ref_lost_n(refLostN),
    .spread_select_pin(spreadPin), .enablePinN(enablePinN), .freqSelPin(freqSelPin),
    .freqSelRegCtrl(freqSelRegCtrl), .freqSelReg(freqSelReg), .smbClkIn(scl), .smbDataIn(sdaLine),
    .smbDataOut(smbDataOut), .smbDataOe(smbDataOe), .hundredSpread(hundredSpread),
    .selectableSpread(selectableSpread), .spreadSrcFilter(spreadSrcFilter), .selFreq25(selFreq25));
  cga_smb_host #(.ADDR(ADDR)) i_host (.core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow),
    .rdByte(rdByte), .rdValid(rdValid));
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic push(input logic [7:0] m, input logic [7:0] x);
    expQ.push_back({m, x});
  endtask
  // new random pin levels, then let the synchronisers settle
  task automatic newPins(input int settle);
    logic [31:0] r;
    r = xorshift();
    refLostN <= r[0];
    spreadPin <= r[2:1];
    enablePinN <= r[9:3];
    freqSelPin <= r[10];
    freqSelRegCtrl <= r[11];
    freqSelReg <= r[12];
    repeat (settle) @(posedge core_clk);
  endtask
  // outputs, then a block read of indices 3 to 8
  task automatic checkAll(input logic [7:0] dm);
    hs = spr[2] ? spr[1:0] : spreadPin;
    check({6'h0, hundredSpread}, {6'h0, hs});
    check({6'h0, selectableSpread}, (freqSelRegCtrl ? freqSelReg : freqSelPin) ? 8'h00 : {6'h0, hs});
    check({7'h0, selFreq25}, {7'h0, freqSelRegCtrl ? freqSelReg : freqSelPin});
    check({7'h0, spreadSrcFilter}, {7'h0, spr[3]});
    push(8'hFF, READ_COUNT_EXP);
    push(8'hFF, {refLostN, 7'h00});
    push(dm & 8'hFC, 8'hFC);
    push(dm, 8'hFF);
    push(8'hFF, {2'b00, spreadPin, spr});
    push(8'hFF, {1'b0, enablePinN ^ 7'h79});
    push(8'hFF, 8'h00);
    i_host.rd(REG_REF_MON, 6);
  endtask
  task automatic deltaRead(input logic [7:0] lo, input logic [7:0] hi);
    push(8'hFF, READ_COUNT_EXP);
    push(8'hFC, lo);
    push(8'hFF, hi);
    i_host.rd(REG_DELTA_LO, 2);
  endtask
  // result watcher and run limit
  always @(posedge core_clk)
  begin
    cycles++;
    if (rdValid === 1'b1)
    begin
      if (expQ.size() == 0)
      begin
        mismatches++;
        $display("unexpected at %0t: extra byte", $time);
      end
      else
      begin
        e = expQ.pop_front();
        check(rdByte & e[15:8], e[7:0] & e[15:8]);
      end
    end
    if (cycles >= 95000)
    begin
      mismatches++;
      $display("unexpected at %0t: run limit reached", $time);
      print_verdict();
    end
  end
  // main sequence
  initial
  begin
    newPins(0);
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    spr = {2'b00, spreadPin};
    checkAll(8'h00);
    i_host.wr(7'h6A, REG_REF_MON, 8'h60, ok);
    check({7'h0, ok}, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      newPins(8);
      d = 8'(xorshift());
      d[1:0] = i[1:0];
      i_host.wr(ADDR, REG_SPREAD, d, ok);
      check({7'h0, ok}, 8'h01);
      spr = d[3:0];
      i_host.wr(ADDR, REG_OE_RB, d, ok);
      i_host.wr(ADDR, REG_DELTA_HI, d, ok);
      i_host.wr(ADDR, REG_REF_MON, d & 8'h9F, ok);
      checkAll(8'hFF);
    end
    i_host.wr(ADDR, REG_REF_MON, 8'h40, ok);
    deltaRead(8'hFC, 8'hFF);
    i_host.wr(ADDR, REG_REF_MON, 8'h60, ok);
    deltaRead(8'h00, 8'h00);
    i_host.wr(ADDR, REG_REF_MON, 8'h40, ok);
    repeat (2500) @(posedge core_clk);
    deltaRead(8'h00, 8'h00);
    i_host.wr(ADDR, REG_REF_MON, 8'h00, ok);
    repeat (2500) @(posedge core_clk);
    deltaRead(8'hFC, 8'hFF);
    print_verdict();
  end
endmodule

/* File: shared/cga_meas_if.sv */
// carrier for the frequency-delta result between meter and register bank
`timescale 1ns/1ps
interface cga_meas_if;
  logic [15:0] delta;
  logic update;
  modport src (output delta, output update);
  modport dst (input delta, input update);
endinterface

/* File: shared/cga_pkg.sv */
// constants, register map and encodings for the clock generator auxiliary register slice
package cga_pkg;
  // register byte indices
  localparam logic [7:0] REG_REF_MON = 8'h03;
  localparam logic [7:0] REG_DELTA_LO = 8'h04;
  localparam logic [7:0] REG_DELTA_HI = 8'h05;
  localparam logic [7:0] REG_SPREAD = 8'h06;
  localparam logic [7:0] REG_OE_RB = 8'h07;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // field positions
  localparam int REF_LOST_BIT = 7;
  localparam int FREEZE_BIT = 6;
  localparam int CLEAR_BIT = 5;
  localparam int SRC_BIT = 3;
  localparam int PINCTRL_BIT = 2;
  localparam int SPREAD_SEL_LSB = 0;
  // enable readback bits that read 1 when their pin is low
  localparam logic [6:0] OE_INVERT_MASK = 7'h79;
  // reset values of writable fields
  localparam logic FREEZE_RST = 1'b0;
  localparam logic CLEAR_RST = 1'b0;
  localparam logic SRC_RST = 1'b0;
  localparam logic PINCTRL_RST = 1'b0;
  // delta saturation limits
  localparam logic [15:0] DELTA_MAX = 16'h7FFF;
  localparam logic [15:0] DELTA_MIN = 16'h8000;
  localparam logic [15:0] DELTA_ZERO = 16'h0000;
  // core cycles over which reset is stretched for the link-clock side
  localparam logic [6:0] LINK_RST_HOLD = 7'h50;
  // serial engine
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [1:0] {
    SPREAD_OFF = 2'b00,
    SPREAD_03 = 2'b01,
    SPREAD_RSVD = 2'b10,
    SPREAD_05 = 2'b11
  } cga_spread_t;
  typedef enum logic [1:0] {
    PHASE_CMD = 2'b00,
    PHASE_COUNT = 2'b01,
    PHASE_DATA = 2'b10
  } cga_phase_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TXACK = 3'b101
  } cga_smb_state_t;
endpackage

/* File: verilog/cga_aux_regs.sv */
// reference-monitor, frequency-delta, spread and enable-readback bytes behind a serial slave
// Behaviour
// - host reaches bytes by block write/read: start index, then byte count
// - byte 3 bit 7 shows the live lost-reference pin level
// - byte 3 bit 6 freezes both delta bytes while set
// - byte 3 bit 5 forces both delta bytes to zero while set
// - delta bytes hold signed reference-minus-local difference, updated once per measurement window
// - byte 4 carries result bits 7..0, byte 5 the upper part
// - byte 5 bits 6..0 carry bits 14..8, bit 7 the sign
// - byte 6 bits 5..4 show the live spread pin code
// - byte 6 bit 3 picks spread source: crystal or filter PLL
// - filter PLL source gives no output synchronisation guarantee
// - byte 6 bit 2 hands spread control from pin to register
// - byte 6 bits 1..0 register spread code, loaded from pin at reset
// - frequency select from pin, or register bit under register control
// - byte 7 bits 6..0 show enable pins; 6,5,4,3,0 read 1 when low
// - byte 7 bits 2,1 read 1 when their pin is high
`timescale 1ns/1ps
module cga_aux_regs
  import cga_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h69,
  parameter logic [7:0] READ_COUNT = 8'h08,
  parameter int WINDOW_REF = 65536,
  parameter int EXPECT_CORE = 1048576
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic platform_time_input,
  input wire logic ref_lost_n,
  input wire logic [1:0] spread_select_pin,
  input wire logic [6:0] enablePinN,
  input wire logic freqSelPin,
  input wire logic freqSelRegCtrl,
  input wire logic freqSelReg,
  input wire logic smbClkIn,
  input wire logic smbDataIn,
  output logic smbDataOut,
  output logic smbDataOe,
  output cga_pkg::cga_spread_t hundredSpread,
  output cga_pkg::cga_spread_t selectableSpread,
  output logic spreadSrcFilter,
  output logic selFreq25
);
  import cga_pkg::*;

  localparam int SYNC_W = 13;
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h1800;

  cga_meas_if meas ();
  logic [SYNC_W-1:0] pinS;
  logic sclS, sdaS, lostS, freqSelPinS;
  logic [1:0] spreadPinS;
  logic [6:0] oePinS;
  logic sclPrev_q, sdaPrev_q;
  logic sclRise, sclFall, startEv, stopEv;
  cga_smb_state_t state_q, state_d;
  cga_phase_t phase_q, phase_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] remain_q, remain_d;
  logic read_q, read_d;
  logic txFirst_q, txFirst_d;
  logic ackOn_q, ackOn_d;
  logic sdaOe_q, sdaOe_d;
  logic sdaOut_q;
  logic wrEn;
  logic [7:0] wrIdx, wrData, rxByte, txByte;
  logic freeze_q, freeze_d, clear_q, clear_d;
  logic src_q, src_d, pinCtrlDis_q, pinCtrlDis_d;
  logic [1:0] spreadSel_q, spreadSel_d;
  logic spreadLoaded_q, spreadLoaded_d;
  logic [15:0] delta_q, delta_d;
  logic [1:0] effSpread;
  logic effFreq25;
  cga_spread_t hundred_q, hundred_d, selectable_q, selectable_d;
  logic srcOut_q, freq25_q;

  // pins cross into the core domain unreset, so the spread pin is valid right after reset
  cga_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) uPins (
    .clk(core_clk),
    .rst(1'b0),
    .d({smbClkIn, smbDataIn, ref_lost_n, spread_select_pin, enablePinN, freqSelPin}),
    .q(pinS)
  );
  assign {sclS, sdaS, lostS, spreadPinS, oePinS, freqSelPinS} = pinS;

  // link-clock frequency meter
  cga_freq_meter #(.WINDOW_REF(WINDOW_REF), .EXPECT_CORE(EXPECT_CORE), .CNT_W(24)) uMeter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .refClk(platform_time_input),
    .meas(meas.src)
  );

  // byte image seen by a block read
  function automatic logic [7:0] readByte(input logic [7:0] idx);
    logic [7:0] r;
    r = ZERO_BYTE;
    case (idx)
      REG_REF_MON: r = {lostS, freeze_q, clear_q, 5'h00};
      REG_DELTA_LO: r = delta_q[7:0];
      REG_DELTA_HI: r = delta_q[15:8];
      REG_SPREAD: r = {2'b00, spreadPinS, src_q, pinCtrlDis_q, spreadSel_q};
      REG_OE_RB: r = {1'b0, oePinS ^ OE_INVERT_MASK};
      default: r = ZERO_BYTE;
    endcase
    return r;
  endfunction

  // serial line events from synchronised levels
  assign sclRise = sclS & ~sclPrev_q;
  assign sclFall = ~sclS & sclPrev_q;
  assign startEv = sclS & sclPrev_q & ~sdaS & sdaPrev_q;
  assign stopEv = sclS & sclPrev_q & sdaS & ~sdaPrev_q;
  assign rxByte = {shift_q[6:0], sdaS};

  // block read/write slave engine
  always_comb
  begin
    state_d = state_q;
    phase_d = phase_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    remain_d = remain_q;
    read_d = read_q;
    txFirst_d = txFirst_q;
    ackOn_d = ackOn_q;
    sdaOe_d = sdaOe_q;
    wrEn = 1'b0;
    wrIdx = ptr_q;
    wrData = rxByte;
    txByte = txFirst_q ? READ_COUNT : readByte(ptr_q);
    if (startEv)
    begin
      state_d = ST_ADDR;
      phase_d = PHASE_CMD;
      bitCnt_d = BIT_FIRST;
      sdaOe_d = 1'b0;
      ackOn_d = 1'b0;
    end
    else if (stopEv)
    begin
      state_d = ST_IDLE;
      sdaOe_d = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_ADDR:
          if (sclRise)
          begin
            shift_d = rxByte;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == BIT_LAST)
            begin
              read_d = rxByte[0];
              txFirst_d = 1'b1;
              state_d = (rxByte[7:1] == SLAVE_ADDR) ? ST_ACK : ST_IDLE;
            end
          end
        ST_RX:
          if (sclRise)
          begin
            shift_d = rxByte;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == BIT_LAST)
            begin
              state_d = ST_ACK;
              case (phase_q)
                PHASE_CMD:
                begin
                  ptr_d = rxByte;
                  phase_d = PHASE_COUNT;
                end
                PHASE_COUNT:
                begin
                  remain_d = rxByte;
                  phase_d = PHASE_DATA;
                end
                default:
                  if (remain_q != ZERO_BYTE)
                  begin
                    wrEn = 1'b1;
                    ptr_d = ptr_q + 8'h01;
                    remain_d = remain_q - 8'h01;
                  end
              endcase
            end
          end
        ST_ACK:
          if (sclFall)
          begin
            if (!ackOn_q)
            begin
              sdaOe_d = 1'b1; // pull data low to acknowledge
              ackOn_d = 1'b1;
            end
            else
            begin
              ackOn_d = 1'b0;
              bitCnt_d = BIT_FIRST;
              if (read_q)
              begin
                shift_d = txByte; // count byte leads a block read
                sdaOe_d = ~txByte[7];
                txFirst_d = 1'b0;
                state_d = ST_TX;
              end
              else
              begin
                sdaOe_d = 1'b0;
                state_d = ST_RX;
              end
            end
          end
        ST_TX:
          if (sclFall)
            sdaOe_d = ~shift_q[7];
          else if (sclRise)
          begin
            shift_d = {shift_q[6:0], 1'b0};
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == BIT_LAST)
              state_d = ST_TXACK;
          end
        ST_TXACK:
          if (sclFall)
            sdaOe_d = 1'b0;
          else if (sclRise)
          begin
            if (!sdaS)
            begin
              shift_d = txByte;
              ptr_d = ptr_q + 8'h01;
              bitCnt_d = BIT_FIRST;
              state_d = ST_TX;
            end
            else
              state_d = ST_IDLE; // host ended the read
          end
        default: state_d = ST_IDLE;
      endcase
    end
    if (sys_rst)
    begin
      state_d = ST_IDLE;
      phase_d = PHASE_CMD;
      bitCnt_d = BIT_FIRST;
      shift_d = ZERO_BYTE;
      ptr_d = ZERO_BYTE;
      remain_d = ZERO_BYTE;
      read_d = 1'b0;
      txFirst_d = 1'b0;
      ackOn_d = 1'b0;
      sdaOe_d = 1'b0;
      wrEn = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    sclPrev_q <= sys_rst ? 1'b1 : sclS;
    sdaPrev_q <= sys_rst ? 1'b1 : sdaS;
    state_q <= state_d;
    phase_q <= phase_d;
    bitCnt_q <= bitCnt_d;
    shift_q <= shift_d;
    ptr_q <= ptr_d;
    remain_q <= remain_d;
    read_q <= read_d;
    txFirst_q <= txFirst_d;
    ackOn_q <= ackOn_d;
    sdaOe_q <= sdaOe_d;
    sdaOut_q <= 1'b0;
  end

  // writable fields; other bits and bytes take no write
  always_comb
  begin
    freeze_d = freeze_q;
    clear_d = clear_q;
    src_d = src_q;
    pinCtrlDis_d = pinCtrlDis_q;
    spreadSel_d = spreadSel_q;
    spreadLoaded_d = 1'b1;
    if (wrEn)
    begin
      case (wrIdx)
        REG_REF_MON:
        begin
          freeze_d = wrData[FREEZE_BIT];
          clear_d = wrData[CLEAR_BIT];
        end
        REG_SPREAD:
        begin
          src_d = wrData[SRC_BIT];
          pinCtrlDis_d = wrData[PINCTRL_BIT];
          spreadSel_d = wrData[SPREAD_SEL_LSB +: 2];
        end
        default: freeze_d = freeze_q;
      endcase
    end
    // first edge after reset latches the synchronised spread pin
    if (!spreadLoaded_q)
      spreadSel_d = spreadPinS;
    if (sys_rst)
    begin
      freeze_d = FREEZE_RST;
      clear_d = CLEAR_RST;
      src_d = SRC_RST;
      pinCtrlDis_d = PINCTRL_RST;
      spreadSel_d = SPREAD_OFF;
      spreadLoaded_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    freeze_q <= freeze_d;
    clear_q <= clear_d;
    src_q <= src_d;
    pinCtrlDis_q <= pinCtrlDis_d;
    spreadSel_q <= spreadSel_d;
    spreadLoaded_q <= spreadLoaded_d;
  end

  // delta bytes: clear wins, then freeze holds, else follow the meter
  always_comb
  begin
    delta_d = delta_q;
    if (sys_rst || clear_q)
      delta_d = DELTA_ZERO;
    else if (meas.update && !freeze_q)
      delta_d = meas.delta;
  end

  always_ff @(posedge core_clk)
  begin
    delta_q <= delta_d;
  end

  // effective spread and frequency selection driven to the clock paths
  always_comb
  begin
    effSpread = pinCtrlDis_q ? spreadSel_q : spreadPinS;
    effFreq25 = freqSelRegCtrl ? freqSelReg : freqSelPinS;
    hundred_d = cga_spread_t'(effSpread);
    selectable_d = effFreq25 ? SPREAD_OFF : cga_spread_t'(effSpread);
    if (sys_rst)
    begin
      hundred_d = SPREAD_OFF;
      selectable_d = SPREAD_OFF;
    end
  end

  always_ff @(posedge core_clk)
  begin
    hundred_q <= hundred_d;
    selectable_q <= selectable_d;
    srcOut_q <= sys_rst ? SRC_RST : src_q;
    freq25_q <= sys_rst ? 1'b0 : effFreq25;
  end

  assign smbDataOut = sdaOut_q;
  assign smbDataOe = sdaOe_q;
  assign hundredSpread = hundred_q;
  assign selectableSpread = selectable_q;
  assign spreadSrcFilter = srcOut_q;
  assign selFreq25 = freq25_q;

  // checks
  a_clear_zero: assert property (@(posedge core_clk) disable iff (sys_rst) clear_q |=> delta_q == DELTA_ZERO)
    else $error("delta not cleared");
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (freeze_q && !clear_q) |=> delta_q == $past(delta_q))
    else $error("delta moved while frozen");
  a_delta_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
    (meas.update && !freeze_q && !clear_q) |=> delta_q == $past(meas.delta))
    else $error("delta missed an update");
  a_lost_live: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(ref_lost_n) |-> ##2 lostS == $past(ref_lost_n, 2))
    else $error("lost readback stale");
  a_oe_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##2 oePinS == $past(enablePinN, 2))
    else $error("enable readback wrong");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    !txFirst_q |-> !(ptr_q == REG_OE_RB && txByte[7]) && !(ptr_q == REG_REF_MON && txByte[4:0] != 5'h00))
    else $error("reserved bits not zero");
  a_spread_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
    !spreadLoaded_q |=> spreadSel_q == $past(spreadPinS))
    else $error("spread not latched at reset");
  a_select_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    freq25_q |-> selectable_q == SPREAD_OFF)
    else $error("spread on selectable outputs at 25 MHz");
  a_freq_source: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 freq25_q == $past(freqSelRegCtrl ? freqSelReg : freqSelPinS))
    else $error("frequency select source wrong");
  a_ack_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == ST_ACK && ackOn_q) |-> smbDataOe)
    else $error("acknowledge not driven");
  a_ro_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && wrIdx != REG_REF_MON) |=> freeze_q == $past(freeze_q) && clear_q == $past(clear_q))
    else $error("control moved by foreign write");
endmodule

/* File: verilog/cga_freq_meter.sv */
// measures platform-time clock against the local clock and yields a signed delta
`timescale 1ns/1ps
module cga_freq_meter #(
  parameter int WINDOW_REF = 65536,
  parameter int EXPECT_CORE = 1048576,
  parameter int CNT_W = 24
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic refClk,
  cga_meas_if.src meas
);
  import cga_pkg::*;
  localparam logic [CNT_W-1:0] EXPECT_V = CNT_W'(EXPECT_CORE);
  localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WINDOW_REF - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_FULL = '1;

  logic rstRefS;
  logic [6:0] rstHold_q, rstHold_d;
  logic linkRst_q, linkRst_d;
  logic [CNT_W-1:0] gateCnt_q, gateCnt_d;
  logic gateTgl_q, gateTgl_d;
  logic gateS, gatePrev_q;
  logic [CNT_W-1:0] coreCnt_q, coreCnt_d;
  logic primed_q, primed_d;
  logic [15:0] delta_q, delta_d;
  logic update_q, update_d;
  logic signed [CNT_W+1:0] diff;

  // saturate a wide signed difference to 16 bits
  function automatic logic [15:0] sat16(input logic signed [CNT_W+1:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > $signed({{(CNT_W-14){1'b0}}, DELTA_MAX}))
      r = DELTA_MAX;
    else if (v < -$signed({{(CNT_W-14){1'b0}}, DELTA_MAX}) - 1)
      r = DELTA_MIN;
    return r;
  endfunction

  // a short core reset would slip between slow link edges, so stretch it first
  always_comb
  begin
    rstHold_d = (rstHold_q == '0) ? rstHold_q : rstHold_q - 7'h01;
    linkRst_d = sys_rst | (rstHold_q != '0);
    if (sys_rst)
      rstHold_d = LINK_RST_HOLD;
  end

  always_ff @(posedge core_clk)
  begin
    rstHold_q <= rstHold_d;
    linkRst_q <= linkRst_d;
  end

  // stretched reset brought into the link domain
  cga_sync #(.WIDTH(1), .RST_VAL(1'b1)) uRstRef (.clk(refClk), .rst(1'b0), .d(linkRst_q), .q(rstRefS));

  // link side: toggle once per window of link clock cycles
  always_comb
  begin
    gateCnt_d = (gateCnt_q == WIN_LAST) ? CNT_ZERO : gateCnt_q + CNT_ONE;
    gateTgl_d = (gateCnt_q == WIN_LAST) ? ~gateTgl_q : gateTgl_q;
    if (rstRefS)
    begin
      gateCnt_d = CNT_ZERO;
      gateTgl_d = 1'b0;
    end
  end

  always_ff @(posedge refClk)
  begin
    gateCnt_q <= gateCnt_d;
    gateTgl_q <= gateTgl_d;
  end

  // window toggle crosses into the core domain
  cga_sync #(.WIDTH(1), .RST_VAL(1'b0)) uGate (.clk(core_clk), .rst(sys_rst), .d(gateTgl_q), .q(gateS));

  // core side: count local cycles per window, delta = expected - measured
  always_comb
  begin
    diff = $signed({2'b00, EXPECT_V}) - $signed({2'b00, coreCnt_q});
    coreCnt_d = (coreCnt_q == CNT_FULL) ? coreCnt_q : coreCnt_q + CNT_ONE;
    primed_d = primed_q;
    delta_d = delta_q;
    update_d = 1'b0;
    if (gateS != gatePrev_q)
    begin
      coreCnt_d = CNT_ONE;
      primed_d = 1'b1;
      if (primed_q)
      begin
        delta_d = sat16(diff);
        update_d = 1'b1;
      end
    end
    if (sys_rst)
    begin
      coreCnt_d = CNT_ONE;
      primed_d = 1'b0;
      delta_d = DELTA_ZERO;
      update_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    gatePrev_q <= sys_rst ? 1'b0 : gateS;
    coreCnt_q <= coreCnt_d;
    primed_q <= primed_d;
    delta_q <= delta_d;
    update_q <= update_d;
  end

  assign meas.delta = delta_q;
  assign meas.update = update_q;
endmodule

/* File: verilog/cga_sync.sv */
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
module cga_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  // next values: first stage feeds only the second
  always_comb
  begin
    meta_d = rst ? RST_VAL : d;
    q_d = rst ? RST_VAL : meta_q;
  end

  // register both stages
  always_ff @(posedge clk)
  begin
    meta_q <= meta_d;
    q <= q_d;
  end
endmodule
